// ### hdl/bidir_serial_msg_framer.sv
// Register access over AHB-Lite is this design's own decision.
module bidir_serial_msg_framer (
   // Clock and reset
   input  wire logic        hclk,
   input  wire logic        hresetn,
   // AHB-Lite slave
   input  wire logic        hsel,
   input  wire logic [31:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   output logic             hreadyout,
   output logic             hresp,
   output logic      [31:0] hrdata,
   // Serial line, byte level
   input  wire logic [7:0]  rx_byte,
   input  wire logic        rx_valid,
   output logic      [7:0]  tx_byte,
   output logic             tx_valid,
   input  wire logic        tx_ready,
   // Controller handshake
   output logic             read_request,
   output logic             receive_done,
   output logic             send_busy,
   output logic             send_done
);

   // ****************************************
   // State
   // ****************************************
   typedef struct packed {
      framer_pkg::state_type state;
      logic [15:0]           len;
      logic [16:0]           cnt;
      logic [16:0]           total;
      logic [15:0]           sum;
      logic [15:0]           rx_sum;
      logic [15:0]           err;
      logic                  overflow;
      logic                  sum_en;
      logic                  word_unit;
      logic [15:0]           tx_len;
      logic [15:0]           rx_len;
      logic                  send_req;
      logic                  read_req;
      logic                  rx_done;
      logic                  send_done;
      logic                  send_err;
      logic [15:0]           send_result;
      logic [15:0]           recv_result;
      logic [7:0]            tx_byte;
      logic                  tx_valid;
      logic                  dp_write;
      logic [11:0]           dp_idx;
      logic [31:0]           hrdata;
   } regs_type;

   regs_type s;
   regs_type next_s;

   logic [11:0]                        a_idx;
   logic                               a_phase;
   logic                               a_mapped;
   logic                               sent;
   logic                               emit;
   logic [7:0]                         emit_byte;
   logic                               cmd_send;
   logic                               cmd_read_done;
   logic                               cmd_clear;
   logic                               rx_wr_en;
   logic [framer_pkg::STORE_IDX_W-1:0] rx_wr_idx;
   logic [15:0]                        rx_wr_data;
   logic [15:0]                        rx_wr_mask;
   logic                               tx_wr_en;
   logic [15:0]                        rx_rd_data;
   logic [15:0]                        tx_rd_bus;
   logic [15:0]                        tx_rd_line;
   logic [16:0]                        tx_total;
   logic [16:0]                        len_total;
   logic [16:0]                        cnt_inc;
   logic [15:0]                        byte_ext;

   // ****************************************
   // Storage areas
   // ****************************************
   word_store #(
      .WIDTH (framer_pkg::WORD_W),
      .DEPTH (framer_pkg::STORE_DEPTH),
      .IDX_W (framer_pkg::STORE_IDX_W)
   ) u_rx_area (
      .hclk      (hclk),
      .hresetn   (hresetn),
      .wr_en     (rx_wr_en),
      .wr_idx    (rx_wr_idx),
      .wr_data   (rx_wr_data),
      .wr_mask   (rx_wr_mask),
      .rd_a_idx  (a_idx[framer_pkg::STORE_IDX_W-1:0]),
      .rd_a_data (rx_rd_data),
      .rd_b_idx  ('0),
      .rd_b_data ()
   );

   word_store #(
      .WIDTH (framer_pkg::WORD_W),
      .DEPTH (framer_pkg::STORE_DEPTH),
      .IDX_W (framer_pkg::STORE_IDX_W)
   ) u_tx_area (
      .hclk      (hclk),
      .hresetn   (hresetn),
      .wr_en     (tx_wr_en),
      .wr_idx    (s.dp_idx[framer_pkg::STORE_IDX_W-1:0]),
      .wr_data   (hwdata[15:0]),
      .wr_mask   ('1),
      .rd_a_idx  (a_idx[framer_pkg::STORE_IDX_W-1:0]),
      .rd_a_data (tx_rd_bus),
      .rd_b_idx  (s.cnt[framer_pkg::STORE_IDX_W:1]),
      .rd_b_data (tx_rd_line)
   );

   // ****************************************
   // Next state
   // ****************************************
   always_comb begin
      next_s        = s;
      a_idx         = haddr[13:2];
      a_mapped      = (haddr[31:14] == 18'h0_0000);
      a_phase       = hsel && htrans[framer_pkg::HTRANS_ACT_BIT] && hready;
      sent          = s.tx_valid && tx_ready;
      emit          = 1'b0;
      emit_byte     = framer_pkg::BYTE_ZERO;
      rx_wr_en      = 1'b0;
      rx_wr_idx     = s.cnt[framer_pkg::STORE_IDX_W:1];
      rx_wr_data    = 16'h0000;
      rx_wr_mask    = 16'h0000;
      tx_wr_en      = 1'b0;
      cmd_send      = 1'b0;
      cmd_read_done = 1'b0;
      cmd_clear     = 1'b0;
      byte_ext      = {8'h00, rx_byte};
      cnt_inc       = s.cnt + 17'h0_0001;
      // Unit setting decides the byte count of the data portion
      len_total     = s.word_unit ? {s.len, 1'b0} : {1'b0, s.len};
      tx_total      = s.word_unit ? {s.tx_len, 1'b0} : {1'b0, s.tx_len};

      // ****************************************
      // Bus address phase: capture, prepare read data
      // ****************************************
      next_s.dp_write = a_phase && hwrite;
      next_s.dp_idx   = a_mapped ? a_idx : 12'hFFF;
      if (a_phase && !hwrite) begin
         next_s.hrdata = 32'h0000_0000;
         if (!a_mapped) begin
            next_s.hrdata = 32'h0000_0000;
         end else if (a_idx == framer_pkg::IDX_CTRL) begin
            next_s.hrdata[framer_pkg::CTRL_SUM_BIT]  = s.sum_en;
            next_s.hrdata[framer_pkg::CTRL_WORD_BIT] = s.word_unit;
         end else if (a_idx == framer_pkg::IDX_STATUS) begin
            next_s.hrdata[framer_pkg::STAT_READ_REQ]  = s.read_req;
            next_s.hrdata[framer_pkg::STAT_RX_DONE]   = s.rx_done;
            next_s.hrdata[framer_pkg::STAT_SEND_BUSY] = s.send_req;
            next_s.hrdata[framer_pkg::STAT_SEND_DONE] = s.send_done;
            next_s.hrdata[framer_pkg::STAT_SEND_ERR]  = s.send_err;
         end else if (a_idx == framer_pkg::IDX_TX_LEN) begin
            next_s.hrdata[15:0] = s.tx_len;
         end else if (a_idx == framer_pkg::IDX_RX_LEN) begin
            next_s.hrdata[15:0] = s.rx_len;
         end else if (a_idx == framer_pkg::IDX_SEND_RESULT) begin
            next_s.hrdata[15:0] = s.send_result;
         end else if (a_idx == framer_pkg::IDX_RECV_RESULT) begin
            next_s.hrdata[15:0] = s.recv_result;
         end else if (a_idx - framer_pkg::IDX_TX_AREA < framer_pkg::AREA_SPAN) begin
            next_s.hrdata[15:0] = tx_rd_bus;
         end else if (a_idx - framer_pkg::IDX_RX_AREA < framer_pkg::AREA_SPAN) begin
            next_s.hrdata[15:0] = rx_rd_data;
         end
      end

      // ****************************************
      // Bus data phase: writes
      // ****************************************
      if (s.dp_write) begin
         if (s.dp_idx == framer_pkg::IDX_CTRL) begin
            next_s.sum_en    = hwdata[framer_pkg::CTRL_SUM_BIT];
            next_s.word_unit = hwdata[framer_pkg::CTRL_WORD_BIT];
         end else if (s.dp_idx == framer_pkg::IDX_CMD) begin
            cmd_send      = hwdata[framer_pkg::CMD_SEND_BIT];
            cmd_read_done = hwdata[framer_pkg::CMD_READ_DONE_BIT];
            cmd_clear     = hwdata[framer_pkg::CMD_CLEAR_BIT];
         end else if (s.dp_idx == framer_pkg::IDX_TX_LEN) begin
            // Length cannot move under a send in progress
            if (!s.send_req) begin
               next_s.tx_len = hwdata[15:0];
            end
         end else if (s.dp_idx >= framer_pkg::IDX_TX_AREA
                      && s.dp_idx < framer_pkg::IDX_TX_AREA + framer_pkg::AREA_SPAN) begin
            tx_wr_en = 1'b1;
         end
      end
      if (cmd_clear) begin
         next_s.rx_done   = 1'b0;
         next_s.send_done = 1'b0;
         next_s.send_err  = 1'b0;
      end
      if (cmd_send && !s.send_req) begin
         next_s.send_req = 1'b1;
      end

      // ****************************************
      // Framer; hardware sets below override clears above
      // ****************************************
      case (s.state)
         framer_pkg::st_idle: begin
            // Stray bytes without a leading enquiry are dropped here
            if (rx_valid && rx_byte == framer_pkg::CODE_ENQ) begin
               next_s.state    = framer_pkg::st_rx_len_lo;
               next_s.sum      = 16'h0000;
               next_s.overflow = 1'b0;
            end else if (s.send_req) begin
               next_s.state = framer_pkg::st_tx_enq;
               next_s.cnt   = 17'h0_0000;
               next_s.sum   = {8'h00, s.tx_len[7:0]} + {8'h00, s.tx_len[15:8]};
            end
         end
         framer_pkg::st_rx_len_lo: begin
            if (rx_valid) begin
               next_s.len[7:0] = rx_byte;
               next_s.sum      = s.sum + byte_ext;
               next_s.state    = framer_pkg::st_rx_len_hi;
            end
         end
         framer_pkg::st_rx_len_hi: begin
            if (rx_valid) begin
               next_s.len[15:8] = rx_byte;
               next_s.sum       = s.sum + byte_ext;
               next_s.cnt       = 17'h0_0000;
               next_s.total     = s.word_unit ? {rx_byte, s.len[7:0], 1'b0} : {1'b0, rx_byte, s.len[7:0]};
               next_s.state     = framer_pkg::st_rx_data;
            end
         end
         framer_pkg::st_rx_data: begin
            // Sum low byte may follow the last data byte with no gap
            if (s.cnt == s.total && !s.sum_en) begin
               next_s.state = framer_pkg::st_rx_check;
            end else if (s.cnt == s.total) begin
               if (rx_valid) begin
                  next_s.rx_sum[7:0] = rx_byte;
                  next_s.state       = framer_pkg::st_rx_sum_hi;
               end
            end else if (rx_valid) begin
               next_s.sum = s.sum + byte_ext;
               next_s.cnt = cnt_inc;
               if (s.cnt < framer_pkg::STORE_BYTES) begin
                  rx_wr_en = 1'b1;
                  // Low half written with a zero high half, fixed up by the next byte
                  if (!s.cnt[0]) begin
                     rx_wr_data = {framer_pkg::BYTE_ZERO, rx_byte};
                     rx_wr_mask = 16'hFFFF;
                  end else begin
                     rx_wr_data = {rx_byte, framer_pkg::BYTE_ZERO};
                     rx_wr_mask = 16'hFF00;
                  end
               end else begin
                  next_s.overflow = 1'b1;
               end
            end
         end
         framer_pkg::st_rx_sum_hi: begin
            if (rx_valid) begin
               next_s.rx_sum[15:8] = rx_byte;
               next_s.state        = framer_pkg::st_rx_check;
            end
         end
         framer_pkg::st_rx_check: begin
            if (s.overflow) begin
               next_s.err   = framer_pkg::ERR_RX_LONG;
               next_s.state = framer_pkg::st_nak;
            end else if (s.sum_en && s.rx_sum != s.sum) begin
               next_s.err   = framer_pkg::ERR_RX_SUM;
               next_s.state = framer_pkg::st_nak;
            end else begin
               next_s.rx_len   = s.len;
               next_s.read_req = 1'b1;
               next_s.state    = framer_pkg::st_wait_read;
            end
         end
         framer_pkg::st_wait_read: begin
            if (cmd_read_done) begin
               next_s.state = framer_pkg::st_ack;
            end
         end
         framer_pkg::st_ack: begin
            emit      = 1'b1;
            emit_byte = framer_pkg::CODE_ACK;
            if (sent) begin
               next_s.read_req = 1'b0;
               next_s.rx_done  = 1'b1;
               next_s.state    = framer_pkg::st_idle;
            end
         end
         framer_pkg::st_nak: begin
            emit      = 1'b1;
            emit_byte = framer_pkg::CODE_NAK;
            if (sent) begin
               next_s.recv_result = s.err;
               next_s.state       = framer_pkg::st_err_lo;
            end
         end
         framer_pkg::st_err_lo: begin
            emit      = 1'b1;
            emit_byte = s.err[7:0];
            if (sent) begin
               next_s.state = framer_pkg::st_err_hi;
            end
         end
         framer_pkg::st_err_hi: begin
            emit      = 1'b1;
            emit_byte = s.err[15:8];
            if (sent) begin
               next_s.state = framer_pkg::st_idle;
            end
         end
         framer_pkg::st_tx_enq: begin
            emit      = 1'b1;
            emit_byte = framer_pkg::CODE_ENQ;
            if (sent) begin
               next_s.state = framer_pkg::st_tx_len_lo;
            end
         end
         framer_pkg::st_tx_len_lo: begin
            emit      = 1'b1;
            emit_byte = s.tx_len[7:0];
            if (sent) begin
               next_s.state = framer_pkg::st_tx_len_hi;
            end
         end
         framer_pkg::st_tx_len_hi: begin
            emit      = 1'b1;
            emit_byte = s.tx_len[15:8];
            if (sent) begin
               next_s.state = framer_pkg::st_tx_data;
            end
         end
         framer_pkg::st_tx_data: begin
            // Counts past the area size wrap back to the first word index
            if (s.cnt == tx_total) begin
               next_s.state = s.sum_en ? framer_pkg::st_tx_sum_lo : framer_pkg::st_tx_wait;
            end else begin
               emit      = 1'b1;
               emit_byte = s.cnt[0] ? tx_rd_line[15:8] : tx_rd_line[7:0];
               if (sent) begin
                  next_s.sum = s.sum + {8'h00, s.tx_byte};
                  next_s.cnt = cnt_inc;
               end
            end
         end
         framer_pkg::st_tx_sum_lo: begin
            emit      = 1'b1;
            emit_byte = s.sum[7:0];
            if (sent) begin
               next_s.state = framer_pkg::st_tx_sum_hi;
            end
         end
         framer_pkg::st_tx_sum_hi: begin
            emit      = 1'b1;
            emit_byte = s.sum[15:8];
            if (sent) begin
               next_s.state = framer_pkg::st_tx_wait;
            end
         end
         framer_pkg::st_tx_wait: begin
            if (rx_valid && rx_byte == framer_pkg::CODE_ACK) begin
               next_s.send_result = framer_pkg::RESULT_RESET;
               next_s.send_req    = 1'b0;
               next_s.send_done   = 1'b1;
               next_s.state       = framer_pkg::st_idle;
            end else if (rx_valid && rx_byte == framer_pkg::CODE_NAK) begin
               next_s.state = framer_pkg::st_tx_err_lo;
            end
         end
         framer_pkg::st_tx_err_lo: begin
            if (rx_valid) begin
               next_s.err[7:0] = rx_byte;
               next_s.state    = framer_pkg::st_tx_err_hi;
            end
         end
         framer_pkg::st_tx_err_hi: begin
            if (rx_valid) begin
               next_s.send_result = {rx_byte, s.err[7:0]};
               next_s.send_req    = 1'b0;
               next_s.send_done   = 1'b1;
               next_s.send_err    = 1'b1;
               next_s.state       = framer_pkg::st_idle;
            end
         end
         default: begin
            next_s.state = framer_pkg::st_idle;
         end
      endcase

      // Line byte is held stable until the far side takes it
      if (sent) begin
         next_s.tx_valid = 1'b0;
      end else if (emit && !s.tx_valid) begin
         next_s.tx_byte  = emit_byte;
         next_s.tx_valid = 1'b1;
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         s       <= '0;
         s.state <= framer_pkg::st_idle;
      end else begin
         s <= next_s;
      end
   end

   // ****************************************
   // Outputs
   // ****************************************
   assign hreadyout    = 1'b1;
   assign hresp        = framer_pkg::HRESP_OKAY;
   assign hrdata       = s.hrdata;
   assign tx_byte      = s.tx_byte;
   assign tx_valid     = s.tx_valid;
   assign read_request = s.read_req;
   assign receive_done = s.rx_done;
   assign send_busy    = s.send_req;
   assign send_done    = s.send_done;

endmodule : bidir_serial_msg_framer

// ### shared/framer_pkg.sv
// Notes on behaviour
// - Every message starts with enquiry 05h
// - Good reception is answered with 06h
// - Bad reception answered 15h plus error code
// - Control codes handled inside, inserted on send
// - Length counts bytes or words per unit setting
// - Length checked; first byte in low half
// - Send length goes out unchanged, low first
// - Data bytes carry any value, no escaping
// - Good data stored from lowest area address
// - Send data until count in chosen unit
// - Checksum is low 16 bits of sum
// - Received checksum verified, never software visible
// - Without checksum, ignore bytes until control code
// - Checksum appended on send only when enabled
// - Received error code becomes send result
// - Sent error code copied to receive result
// - Good message raises receive read request
// - After read: send acknowledge, set done flag
// - On error: no read request, send negative
// - Reception spans enquiry to last sum byte, or last data byte without checksum
// - Odd byte count: final upper byte zero
package framer_pkg;

   // ****************************************
   // Line codes
   // ****************************************
   localparam logic [7:0]  CODE_ENQ  = 8'h05;
   localparam logic [7:0]  CODE_ACK  = 8'h06;
   localparam logic [7:0]  CODE_NAK  = 8'h15;
   localparam logic [7:0]  BYTE_ZERO = 8'h00;

   // ****************************************
   // Storage areas
   // ****************************************
   localparam int          WORD_W      = 16;
   localparam int          STORE_DEPTH = 16;
   localparam int          STORE_IDX_W = 4;
   localparam logic [16:0] STORE_BYTES = 17'h0_0020;
   localparam logic [11:0] AREA_SPAN   = 12'h010;

   // ****************************************
   // Register indexes (byte address is four times)
   // ****************************************
   localparam logic [11:0] IDX_CTRL        = 12'h000;
   localparam logic [11:0] IDX_STATUS      = 12'h001;
   localparam logic [11:0] IDX_CMD         = 12'h002;
   localparam logic [11:0] IDX_TX_LEN      = 12'h003;
   localparam logic [11:0] IDX_RX_LEN      = 12'h004;
   localparam logic [11:0] IDX_SEND_RESULT = 12'h257;
   localparam logic [11:0] IDX_RECV_RESULT = 12'h258;
   localparam logic [11:0] IDX_TX_AREA     = 12'h400;
   localparam logic [11:0] IDX_RX_AREA     = 12'h600;

   // ****************************************
   // Field positions and reset values
   // ****************************************
   localparam int          CTRL_SUM_BIT      = 0;
   localparam int          CTRL_WORD_BIT     = 1;
   localparam int          CMD_SEND_BIT      = 0;
   localparam int          CMD_READ_DONE_BIT = 1;
   localparam int          CMD_CLEAR_BIT     = 2;
   localparam int          STAT_READ_REQ     = 0;
   localparam int          STAT_RX_DONE      = 1;
   localparam int          STAT_SEND_BUSY    = 2;
   localparam int          STAT_SEND_DONE    = 3;
   localparam int          STAT_SEND_ERR     = 4;
   localparam logic [15:0] RESULT_RESET      = 16'h0000;
   localparam logic [15:0] ERR_RX_SUM        = 16'h7001;
   localparam logic [15:0] ERR_RX_LONG       = 16'h7002;
   localparam int          HTRANS_ACT_BIT    = 1;
   localparam logic        HRESP_OKAY        = 1'b0;

   // ****************************************
   // Framer states
   // ****************************************
   typedef enum logic [4:0] {
      st_idle, st_rx_len_lo, st_rx_len_hi, st_rx_data, st_rx_sum_lo, st_rx_sum_hi,
      st_rx_check, st_wait_read, st_ack, st_nak, st_err_lo, st_err_hi,
      st_tx_enq, st_tx_len_lo, st_tx_len_hi, st_tx_data, st_tx_sum_lo, st_tx_sum_hi,
      st_tx_wait, st_tx_err_lo, st_tx_err_hi
   } state_type;

endpackage : framer_pkg

// ### hdl/word_store.sv
module word_store #(
   parameter int WIDTH = 16,
   parameter int DEPTH = 16,
   parameter int IDX_W = 4
) (
   // Clock and reset
   input  wire logic             hclk,
   input  wire logic             hresetn,
   // Write port, bit mask selects lanes
   input  wire logic             wr_en,
   input  wire logic [IDX_W-1:0] wr_idx,
   input  wire logic [WIDTH-1:0] wr_data,
   input  wire logic [WIDTH-1:0] wr_mask,
   // Two read ports
   input  wire logic [IDX_W-1:0] rd_a_idx,
   output logic      [WIDTH-1:0] rd_a_data,
   input  wire logic [IDX_W-1:0] rd_b_idx,
   output logic      [WIDTH-1:0] rd_b_data
);

   typedef struct packed {
      logic [DEPTH-1:0][WIDTH-1:0] mem;
   } store_type;

   store_type s;
   store_type next_s;

   always_comb begin
      next_s = s;
      if (wr_en) begin
         next_s.mem[wr_idx] = (s.mem[wr_idx] & ~wr_mask) | (wr_data & wr_mask);
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         s <= '0;
      end else begin
         s <= next_s;
      end
   end

   assign rd_a_data = s.mem[rd_a_idx];
   assign rd_b_data = s.mem[rd_b_idx];

endmodule : word_store

// ### tb/far_device.sv
module far_device (
   // Clock
   input  wire logic       hclk,
   // Line from the framer
   input  wire logic [7:0] tx_byte,
   input  wire logic       tx_valid,
   output logic            tx_ready,
   // Line to the framer
   output logic      [7:0] rx_byte,
   output logic            rx_valid,
   input  wire logic       slow
);
   timeunit 1ns;
   timeprecision 1ps;
   // ****
   // Far end of the line
   // ****
   logic [7:0] got[$];
   initial begin
      tx_ready = 1'b0;
      rx_byte  = 8'h00;
      rx_valid = 1'b0;
   end
   always @(posedge hclk) begin
      if (tx_valid && tx_ready)
         got.push_back(tx_byte);
      tx_ready <= slow ? !tx_ready : 1'b1;
   end
   task automatic put(input logic [7:0] b, input bit last = 1'b0);
      rx_byte  <= b;
      rx_valid <= 1'b1;
      @(posedge hclk);
      if (last) rx_valid <= 1'b0;
      if (last) rx_byte <= ~b; // Stale byte must not look valid
   endtask : put
   // Byte units; flip corrupts the sum on purpose
   task automatic frame(input logic [7:0] d[$], input logic [7:0] flip);
      logic [15:0] s;
      s = 16'(d.size());
      put(8'h05);
      put(s[7:0]);
      put(s[15:8]);
      foreach (d[i]) begin
         s = s + 16'(d[i]);
         put(d[i]);
      end
      put(s[7:0] ^ flip);
      put(s[15:8], 1'b1);
   endtask : frame
endmodule : far_device

// ### tb/framer_chk.sv
module framer_chk (
   // Clock and reset
   input wire logic       hclk,
   input wire logic       hresetn,
   // Line and handshake
   input wire logic [7:0] tx_byte,
   input wire logic       tx_valid,
   input wire logic       tx_ready,
   input wire logic       read_request,
   input wire logic       receive_done,
   input wire logic       send_busy,
   input wire logic       send_done
);
   timeunit 1ns;
   timeprecision 1ps;
   // ****
   // Properties
   // ****
   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);
   tx_hold_a: assert property (tx_valid && !tx_ready |=> tx_valid && $stable(tx_byte))
      else $error("tx byte not held");
   byte_gap_a: assert property (tx_valid && tx_ready |=> !tx_valid)
      else $error("no gap after byte");
   send_enq_a: assert property ($rose(send_busy) |-> ##[1:3] (tx_valid && tx_byte == framer_pkg::CODE_ENQ))
      else $error("send not opened by enquiry");
   nak_no_req_a: assert property (tx_valid && tx_byte == framer_pkg::CODE_NAK |-> !read_request)
      else $error("request during negative answer");
   ack_done_a: assert property (tx_valid && tx_ready && tx_byte == framer_pkg::CODE_ACK && read_request
      |=> receive_done && !read_request) else $error("ack did not finish read");
   req_drop_a: assert property ($fell(read_request) |-> $past(tx_ready) && $past(tx_byte) == 8'h06)
      else $error("request dropped without ack");
   rx_done_a: assert property ($rose(receive_done) |-> $past(tx_byte) == framer_pkg::CODE_ACK)
      else $error("done without ack");
   done_idle_a: assert property ($rose(send_done) |-> !send_busy)
      else $error("send done while busy");
   cover property ($rose(read_request));
   cover property ($rose(send_done));
   cover property (tx_valid && tx_byte == framer_pkg::CODE_NAK);
endmodule : framer_chk
bind bidir_serial_msg_framer framer_chk chk_u (.hclk, .hresetn, .tx_byte, .tx_valid, .tx_ready, .read_request,
   .receive_done, .send_busy, .send_done);

// ### tb/bidir_serial_msg_framer_tb_top.sv
module bidir_serial_msg_framer_tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   logic        hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0, slow = 1'b0;
   logic [31:0] haddr = '0, hwdata = '0, hrdata;
   logic [1:0]  htrans = 2'b00;
   logic [2:0]  hsize = 3'b010;
   logic [7:0]  tx_byte, rx_byte;
   logic        hreadyout, hresp, tx_valid, tx_ready, rx_valid, read_request, receive_done, send_busy, send_done;
   int          n_fail = 0, num_checks = 0;
   always #4 hclk = ~hclk;
   bidir_serial_msg_framer dut_u (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
      .hready(hreadyout), .hreadyout, .hresp, .hrdata, .rx_byte, .rx_valid, .tx_byte, .tx_valid, .tx_ready,
      .read_request, .receive_done, .send_busy, .send_done);
   far_device far_u (.hclk, .tx_byte, .tx_valid, .tx_ready, .rx_byte, .rx_valid, .slow);
   // ****
   // Helpers
   // ****
   task automatic report_and_stop();
      if (n_fail == 0 && num_checks > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask : report_and_stop
   task automatic chk(input logic [31:0] a, input logic [31:0] e);
      num_checks++;
      if (a !== e) begin
         n_fail++;
         $display("[ERR] %0t got %h expected %h", $time, a, e);
      end
   endtask : chk
   // Every wait is bounded here
   task automatic tick(inout int n);
      @(posedge hclk);
      if (++n > 400) begin
         n_fail++;
         report_and_stop();
      end
   endtask : tick
   task automatic bus(input logic w, input logic [11:0] idx, input logic [31:0] wd, output logic [31:0] rd);
      int n = 0;
      hsel   <= 1'b1;
      hwrite <= w;
      htrans <= 2'b10;
      haddr  <= {18'h0_0000, idx, 2'b00};
      do tick(n); while (hreadyout !== 1'b1);
      htrans <= 2'b00;
      hwdata <= wd;
      do tick(n); while (hreadyout !== 1'b1);
      rd = hrdata;
   endtask : bus
   task automatic wr(input logic [11:0] idx, input logic [31:0] wd);
      logic [31:0] rd;
      bus(1'b1, idx, wd, rd);
   endtask : wr
   task automatic rd_chk(input logic [11:0] idx, input logic [31:0] e);
      logic [31:0] rd;
      bus(1'b0, idx, 32'h0000_0000, rd);
      chk(rd, e);
   endtask : rd_chk
   // ****
   // Scenarios
   // ****
   task automatic rx_good();
      int n = 0;
      wr(framer_pkg::IDX_CTRL, 32'h0000_0001);
      far_u.frame('{8'h41, 8'h15, 8'h43}, 8'h00);
      do tick(n); while (read_request !== 1'b1);
      rd_chk(framer_pkg::IDX_RX_AREA, 32'h0000_1541);
      rd_chk(framer_pkg::IDX_RX_AREA + 12'h001, 32'h0000_0043);
      rd_chk(framer_pkg::IDX_RX_LEN, 32'h0000_0003);
      wr(framer_pkg::IDX_CMD, 32'h0000_0002);
      do tick(n); while (receive_done !== 1'b1);
      chk(far_u.got.pop_front(), 8'h06);
   endtask : rx_good
   task automatic rx_bad();
      int n = 0;
      far_u.frame('{8'h22}, 8'h01);
      do tick(n); while (far_u.got.size() < 3);
      chk(read_request, 1'b0);
      chk(far_u.got.pop_front(), 8'h15);
      chk(far_u.got.pop_front(), 8'h01);
      chk(far_u.got.pop_front(), 8'h70);
      rd_chk(framer_pkg::IDX_RECV_RESULT, {16'h0000, framer_pkg::ERR_RX_SUM});
   endtask : rx_bad
   task automatic tx_nak();
      int n = 0;
      logic [7:0] e[7] = '{8'h05, 8'h01, 8'h00, 8'hAA, 8'hBB, 8'h66, 8'h01};
      slow <= 1'b1;
      wr(framer_pkg::IDX_CTRL, 32'h0000_0003);
      wr(framer_pkg::IDX_TX_AREA, 32'h0000_BBAA);
      wr(framer_pkg::IDX_TX_LEN, 32'h0000_0001);
      wr(framer_pkg::IDX_CMD, 32'h0000_0001);
      do tick(n); while (far_u.got.size() < 7);
      foreach (e[i]) chk(far_u.got.pop_front(), e[i]);
      far_u.put(8'h15);
      far_u.put(8'h41);
      far_u.put(8'h00, 1'b1);
      do tick(n); while (send_done !== 1'b1);
      rd_chk(framer_pkg::IDX_SEND_RESULT, 32'h0000_0041);
      rd_chk(framer_pkg::IDX_STATUS, 32'h0000_001A);
   endtask : tx_nak
   initial begin
      repeat (2) @(posedge hclk);
      hresetn <= 1'b1;
      rd_chk(framer_pkg::IDX_SEND_RESULT, 32'h0000_0000);
      rd_chk(12'h7FF, 32'h0000_0000);
      rx_good();
      rx_bad();
      tx_nak();
      report_and_stop();
   end
endmodule : bidir_serial_msg_framer_tb_top
